// >>> hdl/pwm_reload_map.svh
/*
  Register offsets, field positions and reset values for the PWM reload block.
  Assumes inclusion by bare name from the design file, the checker and the bench.
*/
`ifndef PWM_RELOAD_MAP_SVH
`define PWM_RELOAD_MAP_SVH
`define OFS_CONTROL 6'h00
`define OFS_IRQ_EN 6'h04
`define OFS_IRQ_FLAG 6'h08
`define OFS_RELOAD 6'h0c
`define OFS_CLKSEL 6'h10
`define OFS_PHASE 6'h14
`define OFS_DUTY 6'h18
`define OFS_PERIOD 6'h1c
`define OFS_OFFSET 6'h20
`define OFS_TIMER 6'h24
`define CTL_EN 7
`define CTL_OUT 5
`define CTL_POL 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 2
`define LD_REQ 7
`define LD_METHOD 6
`define LD_ODO 2
`define LD_SRC_HI 1
`define LD_SRC_LO 0
`define CLK_SEL_HI 1
`define CLK_SEL_LO 0
`define CLK_FAST 2'h1
`define CLK_SLOW 2'h2
`define IRQ_OFS 3
`define IRQ_PH 2
`define IRQ_DC 1
`define IRQ_PR 0
`define RST_PERIOD 16'hffff
`endif

// >>> hdl/pwm_reload_pkg.sv
/*
  Types for the PWM reload block.
  Assumes the map header is on the include path.
*/
package pwm_reload_pkg;
  typedef enum logic [1:0] {
    mode_standard = 2'b00,
    mode_set_match = 2'b01,
    mode_toggle = 2'b10,
    mode_center = 2'b11
  } pwm_mode_t;
  typedef struct packed {
    logic [15:0] phase;
    logic [15:0] duty;
    logic [15:0] period;
    logic [15:0] offset;
    logic offset_direction_select;
  } count_set_t;
  typedef struct packed {
    logic offset_m;
    logic phase_m;
    logic duty_m;
    logic period_m;
  } match_vec_t;
endpackage : pwm_reload_pkg

// >>> hdl/pwm_reload_and_interrupts.sv
/*
  PWM module with double-buffered reload, match interrupt flags and control
  registers behind an Avalon-MM slave. Assumes core_clk_i is the selected PWM
  clock and that peer buffer-load events arrive as one-cycle pulses on it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwm_reload_map.svh"

// Function
// R1 - keep shadow phase, duty, period, offset pairs and offset direction bit
// R2 - software writes reach only shadows until the reload fires; code copies shadows into the operating set every cycle while disabled
// R3 - method bit picks immediate or triggered; request bit always required
// R4 - all four shadow pairs load into operating copies together
// R5 - immediate: load at first period event after request set
// R6 - triggered: peer buffer-load event chosen by two-bit source field
// R7 - triggered: load at first period event after the trigger
// R8 - completed load clears the request bit in hardware
// R9 - request or trigger in a period-match cycle waits one more period
// R10 - keeps running in sleep with either internal oscillator selected
// R11 - four interrupt sources: phase, duty, period, offset match
// R12 - flags set on rising edge of each match event signal
// R13 - control bit 7 enables; bits 6, 1, 0 read zero
// R14 - control bit 5 shows output state, hardware owned; in set-match mode code loads it from bit 5 of control writes
// R15 - control bit 4 set makes the active level low
// R16 - mode field bits 3-2 select center, toggle, set, standard
// R17 - enable register gates each match interrupt; bits 7-4 read zero
// R18 - flags at bits 3..0, forced clear while disabled
// R19 - standard: phase match starts, duty match ends, period resets timer
// R20 - offset direction bit only changes through armed reload; code also copies it from the shadow every cycle while disabled
// R21 - match, period and buffer-load events are one-cycle pulses
// R22 - count register reads return last written shadow values
module pwm_reload_and_interrupts
  import pwm_reload_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] peer_load_event_i,
  input wire logic sleep_i,
  output logic pwm_out_o,
  output logic buffer_load_event_o,
  output logic offset_match_event_o,
  output logic irq_o
);
  count_set_t shadow;
  count_set_t active;
  logic [7:0] pwm_control;
  logic [3:0] pwm_interrupt_enable;
  logic [3:0] irq_flag;
  logic reload_arm_request;
  logic reload_arm_method;
  logic [1:0] reload_trigger_source;
  logic [1:0] clk_select;
  logic trig_seen;
  logic [15:0] waveform_timer;
  logic count_down;
  logic out_state;
  logic ack;
  match_vec_t match_now;
  match_vec_t match_prev;
  logic enabled;
  logic running;
  logic period_hit;
  logic load_now;
  logic wr_hit;
  logic rd_hit;
  logic sw_set_req;
  pwm_mode_t mode;
  logic [31:0] next_readdata;
  logic [15:0] up_match;

  assign enabled = pwm_control[`CTL_EN];
  assign mode = pwm_mode_t'(pwm_control[`CTL_MODE_HI:`CTL_MODE_LO]);
  // in sleep the core clock is assumed gated unless an internal oscillator feeds us
  assign running = enabled && (!sleep_i || clk_select == `CLK_FAST
                               || clk_select == `CLK_SLOW); // see R10
  assign wr_hit = avs_write_i && !ack;
  assign rd_hit = avs_read_i && !ack;
  assign up_match = active.period - active.duty;

  // center mode has its period event at the bottom turn, not at the top
  always_comb begin
    period_hit = 1'b0;
    if (mode == mode_center) begin
      period_hit = count_down && waveform_timer == 16'h0000;
    end else begin
      period_hit = waveform_timer == active.period; // see R19
    end
  end

  // qualified by running so a halted block raises no events
  always_comb begin
    match_now.period_m = running && period_hit;
    match_now.phase_m = running && waveform_timer == active.phase;
    match_now.duty_m = running && waveform_timer == active.duty;
    match_now.offset_m = running && waveform_timer == active.offset
                         && (mode != mode_center || count_down == active.offset_direction_select);
  end

  // a request raised in the period-match cycle itself sees trig/req only next cycle
  assign sw_set_req = wr_hit && avs_address_i == `OFS_RELOAD && avs_byteenable_i[0]
                      && avs_writedata_i[`LD_REQ];
  assign load_now = match_now.period_m && reload_arm_request
                    && (!reload_arm_method || trig_seen); // see R3 see R5 see R7 see R9

  // one-cycle bus answer: waitrequest low in the cycle after the request rises
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack);
    end
  end

  // decoded from the request itself so data stands once waitrequest drops
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address_i)
      `OFS_CONTROL: next_readdata = {24'h000000, pwm_control[`CTL_EN], 1'b0, out_state,
                                     pwm_control[`CTL_POL:`CTL_MODE_LO], 2'b00}; // see R13 see R14
      `OFS_IRQ_EN: next_readdata = {28'h0000000, pwm_interrupt_enable}; // see R17
      `OFS_IRQ_FLAG: next_readdata = {28'h0000000, irq_flag};
      `OFS_RELOAD: next_readdata = {24'h000000, reload_arm_request, reload_arm_method,
                                    3'b000, shadow.offset_direction_select, reload_trigger_source};
      `OFS_CLKSEL: next_readdata = {30'h0, clk_select};
      `OFS_PHASE: next_readdata = {16'h0000, shadow.phase}; // see R22
      `OFS_DUTY: next_readdata = {16'h0000, shadow.duty};
      `OFS_PERIOD: next_readdata = {16'h0000, shadow.period};
      `OFS_OFFSET: next_readdata = {16'h0000, shadow.offset};
      `OFS_TIMER: next_readdata = {16'h0000, waveform_timer};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // software registers; only byte lane 0 carries their bits
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pwm_control <= 8'h00;
      pwm_interrupt_enable <= 4'h0;
      clk_select <= 2'h0;
      reload_arm_method <= 1'b0;
      reload_trigger_source <= 2'h0;
    end else if (wr_hit && avs_byteenable_i[0]) begin
      if (avs_address_i == `OFS_CONTROL) begin
        // reserved bits and the output bit are never stored, so they stay zero
        pwm_control[`CTL_EN] <= avs_writedata_i[`CTL_EN];
        pwm_control[`CTL_POL] <= avs_writedata_i[`CTL_POL];
        pwm_control[`CTL_MODE_HI:`CTL_MODE_LO] <= avs_writedata_i[`CTL_MODE_HI:`CTL_MODE_LO];
      end
      if (avs_address_i == `OFS_IRQ_EN) begin
        pwm_interrupt_enable <= avs_writedata_i[`IRQ_OFS:`IRQ_PR];
      end
      if (avs_address_i == `OFS_CLKSEL) begin
        clk_select <= avs_writedata_i[`CLK_SEL_HI:`CLK_SEL_LO];
      end
      if (avs_address_i == `OFS_RELOAD) begin
        reload_arm_method <= avs_writedata_i[`LD_METHOD];
        reload_trigger_source <= avs_writedata_i[`LD_SRC_HI:`LD_SRC_LO]; // see R6
      end
    end
  end

  // shadow copies, written byte-wise; never touch the running set
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      shadow <= '{phase: 16'h0000, duty: 16'h0000, period: `RST_PERIOD,
                  offset: 16'h0000, offset_direction_select: 1'b0};
    end else if (wr_hit) begin // see R1 see R2
      for (int b = 0; b < 2; b++) begin
        if (avs_byteenable_i[b]) begin
          unique case (avs_address_i)
            `OFS_PHASE: shadow.phase[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            `OFS_DUTY: shadow.duty[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            `OFS_PERIOD: shadow.period[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            `OFS_OFFSET: shadow.offset[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
            default: ;
          endcase
        end
      end
      if (avs_address_i == `OFS_RELOAD && avs_byteenable_i[0]) begin
        shadow.offset_direction_select <= avs_writedata_i[`LD_ODO];
      end
    end
  end

  // while disabled the shadows pass straight through so the first start uses them
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      active <= '{phase: 16'h0000, duty: 16'h0000, period: `RST_PERIOD,
                  offset: 16'h0000, offset_direction_select: 1'b0};
    end else if (load_now || !enabled) begin
      active <= shadow; // see R4 see R20
    end
  end

  // a new request wins over the clear of a load in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reload_arm_request <= 1'b0;
    end else if (sw_set_req) begin
      reload_arm_request <= 1'b1;
    end else if (load_now) begin
      reload_arm_request <= 1'b0; // see R8
    end
  end

  // a trigger coinciding with our own period event is only remembered
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      trig_seen <= 1'b0;
    end else if (!reload_arm_request || load_now) begin
      trig_seen <= 1'b0;
    end else if (peer_load_event_i[reload_trigger_source]) begin
      trig_seen <= 1'b1; // see R6 see R9
    end
  end

  // standard timer wraps at the period count; center mode turns at both ends
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      waveform_timer <= 16'h0000;
      count_down <= 1'b0;
    end else if (!enabled) begin
      waveform_timer <= 16'h0000;
      count_down <= 1'b0;
    end else if (running) begin
      if (mode == mode_center) begin
        if (!count_down && waveform_timer >= active.period) begin
          count_down <= 1'b1;
          waveform_timer <= waveform_timer - 16'h0001;
        end else if (count_down && waveform_timer == 16'h0000) begin
          count_down <= 1'b0;
          waveform_timer <= 16'h0001;
        end else if (count_down) begin
          waveform_timer <= waveform_timer - 16'h0001;
        end else begin
          waveform_timer <= waveform_timer + 16'h0001;
        end
      end else if (period_hit) begin
        waveform_timer <= 16'h0000; // see R19
      end else begin
        waveform_timer <= waveform_timer + 16'h0001;
      end
    end
  end

  // out_state is the active level before polarity; the pin flop applies it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      out_state <= 1'b0;
    end else if (!enabled) begin
      out_state <= 1'b0;
    end else if (running) begin // see R14 see R16
      unique case (mode)
        mode_standard: begin
          if (match_now.duty_m) begin
            out_state <= 1'b0; // see R19
          end else if (match_now.phase_m) begin
            out_state <= 1'b1;
          end
        end
        mode_set_match: begin
          if (wr_hit && avs_address_i == `OFS_CONTROL && avs_byteenable_i[0]) begin
            out_state <= avs_writedata_i[`CTL_OUT];
          end else if (match_now.phase_m) begin
            out_state <= 1'b1;
          end
        end
        mode_toggle: begin
          if (match_now.phase_m) begin
            out_state <= ~out_state;
          end
        end
        mode_center: begin
          if (!count_down && waveform_timer == up_match) begin
            out_state <= 1'b1;
          end else if (count_down && waveform_timer == up_match + 16'h0001) begin
            out_state <= 1'b0;
          end
        end
      endcase
    end
  end

  // previous match levels give the rising edges that the flags need
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      match_prev <= '0;
    end else begin
      match_prev <= match_now;
    end
  end

  // flag writes copy the data bits: 0 clears, 1 sets
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_flag <= 4'h0;
    end else if (!enabled) begin
      irq_flag <= 4'h0; // see R18
    end else begin
      for (int i = 0; i < 4; i++) begin
        // set wins over a software clear landing in the same cycle
        if (match_now[i] && !match_prev[i]) begin
          irq_flag[i] <= 1'b1; // see R11 see R12
        end else if (wr_hit && avs_address_i == `OFS_IRQ_FLAG && avs_byteenable_i[0]) begin
          irq_flag[i] <= avs_writedata_i[i];
        end
      end
    end
  end

  // every pin comes from a flop so peers see clean one-cycle events
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pwm_out_o <= 1'b0;
      buffer_load_event_o <= 1'b0;
      offset_match_event_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      pwm_out_o <= out_state ^ pwm_control[`CTL_POL]; // see R15
      buffer_load_event_o <= load_now; // see R21
      offset_match_event_o <= match_now.offset_m && !match_prev.offset_m;
      irq_o <= |(irq_flag & pwm_interrupt_enable); // see R17
    end
  end
endmodule : pwm_reload_and_interrupts
`default_nettype wire

// >>> tb/pwm_reload_and_interrupts_properties.sv
/*
  Port-level checker for the PWM reload block, bound to its top module.
  Assumes the bus master keeps byteenable lane 0 on for control writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwm_reload_map.svh"
module pwm_reload_and_interrupts_properties (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [3:0] peer_load_event_i,
  input wire logic sleep_i,
  input wire logic pwm_out_o,
  input wire logic buffer_load_event_o,
  input wire logic offset_match_event_o,
  input wire logic irq_o
);
  logic en;
  logic [3:0] ien;
  logic wr_ok;
  // tracked at the accepting edge, so these lag the real registers by one cycle
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      en <= 1'b0;
      ien <= 4'h0;
    end else if (wr_ok && avs_address_i == `OFS_CONTROL) begin
      en <= avs_writedata_i[`CTL_EN];
    end else if (wr_ok && avs_address_i == `OFS_IRQ_EN) begin
      ien <= avs_writedata_i[3:0];
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_answer_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  a_answer_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_answer_asked: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without request");
  a_read_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  a_load_single: assert property (buffer_load_event_o |=> !buffer_load_event_o)
    else $error("load event longer than one cycle");
  a_offset_single: assert property (offset_match_event_o |=> !offset_match_event_o)
    else $error("offset event longer than one cycle");
  a_flags_off: assert property (!en [*3] |-> !irq_o)
    else $error("interrupt while disabled");
  a_irq_gated: assert property (irq_o |-> ien != 4'h0)
    else $error("interrupt with all enables off");
endmodule : pwm_reload_and_interrupts_properties
bind pwm_reload_and_interrupts pwm_reload_and_interrupts_properties u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .peer_load_event_i(peer_load_event_i),
  .sleep_i(sleep_i), .pwm_out_o(pwm_out_o), .buffer_load_event_o(buffer_load_event_o),
  .offset_match_event_o(offset_match_event_o), .irq_o(irq_o));
`default_nettype wire

// >>> tb/peer_model.sv
/*
  Peer PWM modules that hand buffer-load events to the block under test.
  Assumes the peers share core_clk_i with the block.
*/
`timescale 1ns/1ps
`default_nettype none
module peer_model (
  input wire logic core_clk_i,
  output logic [3:0] peer_load_event_o
);
  initial peer_load_event_o = 4'h0;
  task fire(input int idx);
    @(posedge core_clk_i);
    peer_load_event_o <= 4'h1 << idx;
    @(posedge core_clk_i);
    peer_load_event_o <= 4'h0;
  endtask : fire
endmodule : peer_model
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the PWM reload block: register, reload, interrupt
  and sleep tests over Avalon-MM. Assumes the map header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwm_reload_map.svh"
`define CHECK(g, e) chk(32'(g), 32'(e))
module tb;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] address = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic sleep = 1'b0;
  logic [3:0] be = 4'h3;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] t0;
  logic [3:0] peer_ev;
  logic waitreq, pwm_out, load_ev, ofs_ev, irq, got;
  int n_fail = 0;
  int compares = 0;
  int per, hi;
  always #5 core_clk_i = ~core_clk_i;
  pwm_reload_and_interrupts u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(address), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .peer_load_event_i(peer_ev),
    .sleep_i(sleep), .pwm_out_o(pwm_out), .buffer_load_event_o(load_ev),
    .offset_match_event_o(ofs_ev), .irq_o(irq));
  peer_model u_peer (.core_clk_i(core_clk_i), .peer_load_event_o(peer_ev));
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    address <= a;
    rd <= ~w;
    wr <= w;
    wdata <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) n_fail++;
  endtask : bus
  task wrr(input logic [5:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wrr
  task rdc(input logic [5:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHECK(q, e);
  endtask : rdc
  // which: 0 load event, 1 interrupt, 2 offset event; returns early once seen
  task wait_sig(input int which, input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge core_clk_i);
      got = (which == 0) ? load_ev === 1'b1 : (which == 1) ? irq === 1'b1 : ofs_ev === 1'b1;
    end
  endtask : wait_sig
  // cycles between output rises and the active width, sampled at clock edges
  task meas();
    int t;
    t = 0;
    while (pwm_out !== 1'b0 && t < 200) begin @(posedge core_clk_i); t++; end
    while (pwm_out !== 1'b1 && t < 400) begin @(posedge core_clk_i); t++; end
    hi = 0;
    while (pwm_out === 1'b1 && t < 600) begin @(posedge core_clk_i); hi++; t++; end
    per = hi;
    while (pwm_out !== 1'b1 && t < 800) begin @(posedge core_clk_i); per++; t++; end
  endtask : meas
  task print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rdc(`OFS_CONTROL, 32'h0);
    rdc(`OFS_IRQ_EN, 32'h0);
    rdc(`OFS_PERIOD, `RST_PERIOD);
    wrr(6'h3c, 32'hffff);
    rdc(6'h3c, 32'h0);
    wrr(`OFS_CONTROL, 32'h53);
    rdc(`OFS_CONTROL, 32'h10);
    `CHECK(pwm_out, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wrr(`OFS_CONTROL, m << 2);
      rdc(`OFS_CONTROL, m << 2);
    end
    wrr(`OFS_IRQ_EN, 32'hff);
    rdc(`OFS_IRQ_EN, 32'h0f);
    wrr(`OFS_IRQ_EN, 32'h0);
    $display("test registers done");
    wrr(`OFS_PHASE, 32'h2);
    wrr(`OFS_DUTY, 32'h7);
    wrr(`OFS_PERIOD, 32'h9);
    wrr(`OFS_OFFSET, 32'h3);
    wrr(`OFS_CONTROL, 32'h80);
    meas();
    `CHECK(per, 10);
    `CHECK(hi, 5);
    wrr(`OFS_PHASE, 32'h1);
    wrr(`OFS_DUTY, 32'h3);
    wrr(`OFS_PERIOD, 32'h5);
    rdc(`OFS_PERIOD, 32'h5);
    meas();
    `CHECK(per, 10);
    wrr(`OFS_RELOAD, 32'h80);
    wait_sig(0, 24);
    `CHECK(got, 1'b1);
    rdc(`OFS_RELOAD, 32'h0);
    meas();
    `CHECK(per, 6);
    `CHECK(hi, 2);
    $display("test immediate reload done");
    be <= 4'h2;
    wrr(`OFS_PHASE, 32'h3c3c);
    rdc(`OFS_PHASE, 32'h3c01);
    be <= 4'h3;
    wrr(`OFS_PHASE, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wrr(`OFS_PERIOD, 11 + s);
      wrr(`OFS_RELOAD, 32'hc0 | s);
      u_peer.fire((s + 1) % 4);
      wait_sig(0, 40);
      `CHECK(got, 1'b0);
      rdc(`OFS_RELOAD, 32'hc0 | s);
      u_peer.fire(s);
      wait_sig(0, 40);
      `CHECK(got, 1'b1);
      rdc(`OFS_RELOAD, 32'h40 | s);
      meas();
      `CHECK(per, 12 + s);
    end
    $display("test triggered reload done");
    wrr(`OFS_IRQ_EN, 32'h1);
    wait_sig(1, 40);
    `CHECK(got, 1'b1);
    bus(`OFS_IRQ_FLAG, 1'b0, 32'h0);
    `CHECK(q[`IRQ_PR], 1'b1);
    wrr(`OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge core_clk_i);
    `CHECK(irq, 1'b0);
    wait_sig(2, 40);
    `CHECK(got, 1'b1);
    wrr(`OFS_CONTROL, 32'h0);
    rdc(`OFS_IRQ_FLAG, 32'h0);
    $display("test interrupts done");
    wrr(`OFS_CONTROL, 32'h80);
    sleep <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wrr(`OFS_CLKSEL, c);
      bus(`OFS_TIMER, 1'b0, 32'h0);
      t0 = q;
      bus(`OFS_TIMER, 1'b0, 32'h0);
      `CHECK(q !== t0, c == 1 || c == 2);
    end
    sleep <= 1'b0;
    $display("test sleep done");
    wrr(`OFS_CONTROL, 32'h84);
    repeat (20) @(posedge core_clk_i);
    rdc(`OFS_CONTROL, 32'ha4);
    wrr(`OFS_CONTROL, 32'h88);
    meas();
    `CHECK(hi, 14 + 1);
    `CHECK(per, 2 * (14 + 1));
    wrr(`OFS_RELOAD, 32'h04);
    rdc(`OFS_RELOAD, 32'h04);
    $display("test modes done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
